// file: rtl/ssw_top.sv
// setup back end attribute swizzle and interpolation control
`default_nettype none
module ssw_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // vertex slot fill from upstream
  input wire logic slot_we_i,
  input wire logic [ssw_pkg::SSW_SLOT_AW-1:0] slot_addr_i,
  input wire logic [ssw_pkg::SSW_SLOT_W-1:0] slot_data_i,
  // attribute request
  input wire logic req_valid_i,
  input wire logic [4:0] req_attr_i,
  input wire logic req_back_facing_i,
  input wire logic req_point_i,
  input wire logic [1:0] req_corner_i,
  input wire logic [31:0] req_fill_primitive_identifier_i,
  output logic req_ready_o,
  // attribute result
  output logic out_valid_o,
  output logic [4:0] out_attr_o,
  output logic [ssw_pkg::SSW_SLOT_W-1:0] out_data_o,
  output logic out_const_interp_o,
  output logic [3:0] out_wrap_o,
  output logic [3:0] out_linear_o
);
  import ssw_pkg::*;

  // control state
  logic [15:0] attr_ctrl [SSW_NUM_ATTR];
  logic [31:0] sprite_en;
  logic [31:0] const_en;
  logic [31:0] wrap_lo;
  logic [31:0] wrap_hi;
  logic [31:0] cfg;
  logic [SSW_STAT_W-1:0] emit_count;

  // pipeline state
  logic s1_valid;
  logic [4:0] s1_attr;
  logic s1_point;
  logic [1:0] s1_corner;
  logic [31:0] s1_prim;
  logic [15:0] s1_ctrl;
  logic [SSW_SLOT_AW-1:0] rd_addr;
  logic [SSW_SLOT_W-1:0] rd_data;
  logic [SSW_SLOT_W-1:0] next_data;
  logic [3:0] next_wrap;

  // byte-lane merge for wishbone writes
  function automatic logic [31:0] ssw_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction : ssw_merge

  // pick one 32-bit component out of a 128-bit vector
  function automatic logic [31:0] ssw_comp(input logic [SSW_SLOT_W-1:0] v,
                                           input int unsigned c);
    return v[c*SSW_COMP_W +: SSW_COMP_W];
  endfunction : ssw_comp

  // constant fill vector, components ordered w,z,y,x from the top
  function automatic logic [SSW_SLOT_W-1:0] ssw_const_vec(input ssw_csrc_e s,
                                                          input logic [31:0] pid);
    logic [SSW_SLOT_W-1:0] v;
    v = '0;
    unique case (s)
      ssw_const_0000: v = {SSW_F_ZERO, SSW_F_ZERO, SSW_F_ZERO, SSW_F_ZERO};
      ssw_const_0001: v = {SSW_F_ONE, SSW_F_ZERO, SSW_F_ZERO, SSW_F_ZERO};
      ssw_const_1111: v = {SSW_F_ONE, SSW_F_ONE, SSW_F_ONE, SSW_F_ONE};
      fill_primitive_identifier: v = {pid, pid, pid, pid};
    endcase
    return v;
  endfunction : ssw_const_vec

  logic wb_hit;
  logic [5:0] wb_word;
  assign wb_hit = cyc_i && stb_i && !ack_o;
  assign wb_word = adr_i[7:2];
  // halfword pair addressed by the bus, merged outside the clocked process
  logic [31:0] attr_word;
  logic [31:0] attr_merged;
  assign attr_word = {attr_ctrl[{wb_word[3:0], 1'b1}], attr_ctrl[{wb_word[3:0], 1'b0}]};
  assign attr_merged = ssw_merge(attr_word, dat_i, sel_i);

  // one wait state per access; ack drops the cycle after it is given
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= wb_hit;
    end
  end

  // attribute control words: even attribute low half, odd high half
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < SSW_NUM_ATTR; i++) begin
        attr_ctrl[i] <= '0;
      end
    end else if (wb_hit && we_i && adr_i <= SSW_ADR_ATTR_LAST) begin
      attr_ctrl[{wb_word[3:0], 1'b0}] <= attr_merged[15:0] & SSW_CTRL_MASK;
      attr_ctrl[{wb_word[3:0], 1'b1}] <= attr_merged[31:16] & SSW_CTRL_MASK;
    end
  end

  // sprite coordinate mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sprite_en <= '0;
    end else if (wb_hit && we_i && adr_i == SSW_ADR_SPRITE) begin
      sprite_en <= ssw_merge(sprite_en, dat_i, sel_i);
    end
  end

  // constant interpolation mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      const_en <= '0;
    end else if (wb_hit && we_i && adr_i == SSW_ADR_CONST) begin
      const_en <= ssw_merge(const_en, dat_i, sel_i);
    end
  end

  // wrap enables, attributes 0-7 and 8-15
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wrap_lo <= '0;
      wrap_hi <= '0;
    end else if (wb_hit && we_i && adr_i == SSW_ADR_WRAP_LO) begin
      wrap_lo <= ssw_merge(wrap_lo, dat_i, sel_i);
    end else if (wb_hit && we_i && adr_i == SSW_ADR_WRAP_HI) begin
      wrap_hi <= ssw_merge(wrap_hi, dat_i, sel_i);
    end
  end

  // read offset and sprite origin
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg <= '0;
    end else if (wb_hit && we_i && adr_i == SSW_ADR_CFG) begin
      cfg <= ssw_merge(cfg, dat_i, sel_i) & SSW_CFG_MASK;
    end
  end

  // read mux; unmapped addresses read zero and still ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= '0;
    end else if (wb_hit && !we_i) begin
      if (adr_i <= SSW_ADR_ATTR_LAST) begin
        dat_o <= attr_word;
      end else begin
        unique case (adr_i)
          SSW_ADR_SPRITE: dat_o <= sprite_en;
          SSW_ADR_CONST: dat_o <= const_en;
          SSW_ADR_WRAP_LO: dat_o <= wrap_lo;
          SSW_ADR_WRAP_HI: dat_o <= wrap_hi;
          SSW_ADR_CFG: dat_o <= cfg;
          SSW_ADR_STAT: dat_o <= {{(32-SSW_STAT_W){1'b0}}, emit_count};
          default: dat_o <= '0;
        endcase
      end
    end
  end

  // fully pipelined, so a request is never refused
  assign req_ready_o = 1'b1;

  // slot address: read offset plus index, plus one when back-facing in swizzle modes 1 and 3
  always_comb begin
    logic [15:0] c;
    logic face;
    c = attr_ctrl[req_attr_i];
    face = 1'b0;
    if (ssw_swz_e'(c[SSW_F_SWZ_LO +: 2]) == swz_by_facing ||
        ssw_swz_e'(c[SSW_F_SWZ_LO +: 2]) == swz_facing_copy_w) begin
      face = req_back_facing_i;
    end
    // index 0 is the slot at the read offset, each step one slot up
    rd_addr = SSW_SLOT_AW'(cfg[SSW_SLOT_AW-1:0] +
                           {1'b0, c[SSW_F_SRC_LO +: 5]} + {5'h00, face});
  end

  ssw_slot_mem u_slot_mem (
    .clk_i(clk_i),
    .we_i(slot_we_i),
    .waddr_i(slot_addr_i),
    .wdata_i(slot_data_i),
    .raddr_i(rd_addr),
    .rdata_o(rd_data)
  );

  // stage one: hold request beside the memory read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_valid <= 1'b0;
      s1_attr <= '0;
      s1_point <= 1'b0;
      s1_corner <= '0;
      s1_prim <= '0;
      s1_ctrl <= '0;
    end else begin
      s1_valid <= req_valid_i;
      s1_attr <= req_attr_i;
      s1_point <= req_point_i;
      s1_corner <= req_corner_i;
      s1_prim <= req_fill_primitive_identifier_i;
      s1_ctrl <= attr_ctrl[req_attr_i];
    end
  end

  // swizzle, override and sprite replacement
  always_comb begin
    logic [SSW_SLOT_W-1:0] k;
    logic [31:0] s;
    logic [31:0] t;
    k = ssw_const_vec(ssw_csrc_e'(s1_ctrl[SSW_F_CSRC_LO +: 2]), s1_prim);
    // non-point corners share the vertex data as is
    next_data = rd_data;
    if (ssw_swz_e'(s1_ctrl[SSW_F_SWZ_LO +: 2]) == swz_copy_w_to_x ||
        ssw_swz_e'(s1_ctrl[SSW_F_SWZ_LO +: 2]) == swz_facing_copy_w) begin
      next_data[0 +: SSW_COMP_W] = ssw_comp(rd_data, 3);
    end
    for (int c = 0; c < 4; c++) begin
      if (s1_ctrl[SSW_F_OVR_LO + c]) begin
        next_data[c*SSW_COMP_W +: SSW_COMP_W] = ssw_comp(k, c);
      end
    end
    // corner bit 0 picks s, bit 1 picks t; origin flips t
    s = s1_corner[0] ? SSW_F_ONE : SSW_F_ZERO;
    t = (s1_corner[1] ^ cfg[SSW_F_ORIGIN]) ? SSW_F_ONE : SSW_F_ZERO;
    // mask is meaningful only for points, so non-points ignore it
    if (s1_point && sprite_en[s1_attr]) begin
      next_data = {SSW_F_ONE, SSW_F_ZERO, t, s};
    end
  end

  // wrap enables exist only for the low sixteen attributes
  always_comb begin
    next_wrap = 4'h0;
    if (s1_attr < 5'(SSW_WRAP_ATTR)) begin
      if (s1_attr[3]) begin
        next_wrap = wrap_hi[s1_attr[2:0]*4 +: 4];
      end else begin
        next_wrap = wrap_lo[s1_attr[2:0]*4 +: 4];
      end
    end
    if (const_en[s1_attr]) begin
      next_wrap = 4'h0;
    end
  end

  // stage two: registered result
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_valid_o <= 1'b0;
      out_attr_o <= '0;
      out_data_o <= '0;
      out_const_interp_o <= 1'b0;
      out_wrap_o <= '0;
      out_linear_o <= '0;
    end else begin
      out_valid_o <= s1_valid;
      out_attr_o <= s1_attr;
      out_data_o <= next_data;
      out_const_interp_o <= const_en[s1_attr];
      out_wrap_o <= next_wrap;
      // constant attributes interpolate no component linearly
      out_linear_o <= const_en[s1_attr] ? 4'h0 : ~next_wrap;
    end
  end

  // emitted attribute count, wraps at full scale
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      emit_count <= '0;
    end else if (s1_valid) begin
      emit_count <= emit_count + 1'b1;
    end
  end
endmodule : ssw_top
`default_nettype wire

// file: pkg/ssw_pkg.sv
// constants, types and the behaviour overview of the attribute swizzle block
// Overview of operation
// - constant source 0: all 0.0; 1: W 1.0 only; 2: all 1.0; 3: primitive id.
// - a set override bit replaces that component with the selected constant.
// - swizzle mode 0 takes the indexed slot directly, no facing, no copy.
// - modes 1 and 3 use the indexed slot front-facing, next slot back-facing.
// - modes 2 and 3 copy the sourced W component into X.
// - source index 0 is the first 128-bit slot at the read offset.
// - points copy the incoming vertex attributes to every corner unchanged.
// - sprite mask bit set replaces a point's attribute with a per-corner coordinate.
// - sprite mask bit n belongs to output attribute n.
// - constant-interpolation bit set makes it constant, wrap enables ignored.
// - constant bit clear: components without wrap enable interpolate linearly.
// - four wrap bits per attribute, X at bit 0 up to W at bit 3.
// - wrap interpolation exists only for attributes 0 to 15.
`default_nettype none
package ssw_pkg;
  localparam int unsigned SSW_NUM_ATTR = 32;
  localparam int unsigned SSW_WRAP_ATTR = 16;
  localparam int unsigned SSW_SLOT_W = 128;
  localparam int unsigned SSW_SLOT_AW = 6;
  localparam int unsigned SSW_SLOT_DEPTH = 64;
  localparam int unsigned SSW_COMP_W = 32;
  localparam int unsigned SSW_STAT_W = 16;
  // register byte addresses
  localparam logic [7:0] SSW_ADR_ATTR_LAST = 8'h3C;
  localparam logic [7:0] SSW_ADR_SPRITE = 8'h40;
  localparam logic [7:0] SSW_ADR_CONST = 8'h44;
  localparam logic [7:0] SSW_ADR_WRAP_LO = 8'h48;
  localparam logic [7:0] SSW_ADR_WRAP_HI = 8'h4C;
  localparam logic [7:0] SSW_ADR_CFG = 8'h50;
  localparam logic [7:0] SSW_ADR_STAT = 8'h54;
  // per-attribute control halfword fields
  localparam int unsigned SSW_F_SRC_LO = 0;
  localparam int unsigned SSW_F_SWZ_LO = 6;
  localparam int unsigned SSW_F_CSRC_LO = 9;
  localparam int unsigned SSW_F_OVR_LO = 12;
  localparam logic [15:0] SSW_CTRL_MASK = 16'hF6DF;
  // configuration word fields
  localparam int unsigned SSW_F_ORIGIN = 8;
  localparam logic [31:0] SSW_CFG_MASK = 32'h0000013F;
  // float encodings
  localparam logic [31:0] SSW_F_ZERO = 32'h00000000;
  localparam logic [31:0] SSW_F_ONE = 32'h3F800000;
  typedef enum logic [1:0] {
    ssw_const_0000,
    ssw_const_0001,
    ssw_const_1111,
    fill_primitive_identifier
  } ssw_csrc_e;
  typedef enum logic [1:0] {
    swz_direct,
    swz_by_facing,
    swz_copy_w_to_x,
    swz_facing_copy_w
  } ssw_swz_e;
endpackage : ssw_pkg
`default_nettype wire

// file: rtl/ssw_slot_mem.sv
// vertex attribute slot memory with registered read data
`default_nettype none
module ssw_slot_mem (
  // clock
  input wire logic clk_i,
  // write port from the vertex stage
  input wire logic we_i,
  input wire logic [ssw_pkg::SSW_SLOT_AW-1:0] waddr_i,
  input wire logic [ssw_pkg::SSW_SLOT_W-1:0] wdata_i,
  // read port
  input wire logic [ssw_pkg::SSW_SLOT_AW-1:0] raddr_i,
  output logic [ssw_pkg::SSW_SLOT_W-1:0] rdata_o
);
  import ssw_pkg::*;
  logic [SSW_SLOT_W-1:0] mem [SSW_SLOT_DEPTH];

  // no reset: contents are undefined until the vertex stage fills them
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // write-first is not provided; same-cycle read returns the old word
  always_ff @(posedge clk_i) begin
    rdata_o <= mem[raddr_i];
  end
endmodule : ssw_slot_mem
`default_nettype wire

// file: bench/ssw_top_assertions.sv
// timing and result checks of the attribute swizzle block
`default_nettype none
module ssw_top_assertions (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus handshake
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  // attribute path
  input wire logic req_valid_i,
  input wire logic [4:0] req_attr_i,
  input wire logic out_valid_o,
  input wire logic [4:0] out_attr_o,
  input wire logic out_const_interp_o,
  input wire logic [3:0] out_wrap_o,
  input wire logic [3:0] out_linear_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_result;
    ##2 out_valid_o;
  endsequence
  a_ack_answer: assert property (s_take |=> ack_o) else $error("bus access not acked");
  a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  a_ack_cause: assert property ($rose(ack_o) |-> $past(cyc_i) && $past(stb_i))
    else $error("ack without request");
  a_out_latency: assert property (req_valid_i |-> s_result) else $error("result late");
  a_out_cause: assert property (out_valid_o |-> $past(req_valid_i, 2))
    else $error("result without request");
  a_out_attr_num: assert property (req_valid_i |-> ##2 out_attr_o == $past(req_attr_i, 2))
    else $error("wrong attribute number");
  a_const_no_wrap: assert property (out_valid_o && out_const_interp_o |-> out_wrap_o == 4'h0)
    else $error("wrap on constant attribute");
  a_linear_rest: assert property (out_valid_o |->
    out_linear_o == (out_const_interp_o ? 4'h0 : ~out_wrap_o)) else $error("linear set wrong");
  a_wrap_range: assert property (out_valid_o && out_attr_o[4] |-> out_wrap_o == 4'h0)
    else $error("wrap above attribute 15");
endmodule : ssw_top_assertions
bind ssw_top ssw_top_assertions u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .req_valid_i,
  .req_attr_i, .out_valid_o, .out_attr_o, .out_const_interp_o, .out_wrap_o, .out_linear_o);
`default_nettype wire

// file: bench/ssw_vertex_model.sv
// upstream vertex stage that fills every attribute slot once per start
`default_nettype none
module ssw_vertex_model import ssw_pkg::*; (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic start_i,
  output logic done_o,
  // slot write port
  output logic slot_we_o,
  output logic [ssw_pkg::SSW_SLOT_AW-1:0] slot_addr_o,
  output logic [ssw_pkg::SSW_SLOT_W-1:0] slot_data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] cnt;
  logic tog;
  logic [31:0] v;
  always_ff @(posedge clk_i) begin
    tog <= rst_i ? 1'b0 : ~tog;
    if (rst_i || start_i) begin
      cnt <= rst_i ? 7'h40 : 7'h00;
    end else if (!cnt[6]) begin
      cnt <= cnt + 7'h01;
    end
  end
  assign done_o = cnt[6];
  assign slot_we_o = !cnt[6];
  assign slot_addr_o = cnt[5:0];
  assign v = {26'h0, cnt[5:0]};
  // idle data flips each cycle so stale data never looks valid
  assign slot_data_o = cnt[6] ? {128{tog}} :
    {32'h40000000 | v, 32'h30000000 | v, 32'h20000000 | v, 32'h10000000 | v};
endmodule : ssw_vertex_model
`default_nettype wire

// file: bench/tb.sv
// self-checking bench of the attribute swizzle block
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got=%h exp=%h", $time, g, e); end end
module tb import ssw_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, start = 1'b0, rv = 1'b0, back = 1'b0, pnt = 1'b0;
  logic ack, ready, ov, oc, swe, done;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, pid = 32'h0, dat_o, rdat, s_c, t_c;
  logic [4:0] ra = 5'h00, oa;
  logic [1:0] corner = 2'h0, mm, cc;
  logic [3:0] ow, ol, ovr;
  logic [3:0] sel = 4'hF;
  logic [5:0] saddr;
  logic [127:0] sdata, od, e;
  logic [4:0] ia [6] = '{5'h00, 5'h01, 5'h07, 5'h08, 5'h10, 5'h11};
  logic [11:0] ie [6] = '{12'h05A, 12'h100, 12'h0A5, 12'h0C3, 12'h00F, 12'h100};
  int fail_count = 0, samples_checked = 0, nreq = 0, cycles = 0;
  always #5 clk_i = ~clk_i;
  ssw_vertex_model u_vtx (.clk_i, .rst_i, .start_i(start), .done_o(done), .slot_we_o(swe),
    .slot_addr_o(saddr), .slot_data_o(sdata));
  ssw_top u_dut (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(wdat), .dat_o, .ack_o(ack), .slot_we_i(swe), .slot_addr_i(saddr), .slot_data_i(sdata),
    .req_valid_i(rv), .req_attr_i(ra), .req_back_facing_i(back), .req_point_i(pnt),
    .req_corner_i(corner), .req_fill_primitive_identifier_i(pid), .req_ready_o(ready), .out_valid_o(ov),
    .out_attr_o(oa), .out_data_o(od), .out_const_interp_o(oc), .out_wrap_o(ow),
    .out_linear_o(ol));
  task automatic finish_test();
    $display("checks=%0d errors=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s = 4'hF);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    sel <= s;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    wb(1'b0, a, 32'h0);
    `CHK(rdat, x)
  endtask : rd
  task automatic req(input logic [4:0] a, input logic b, input logic p, input logic [1:0] c);
    @(posedge clk_i);
    `CHK(ready, 1'b1)
    rv <= 1'b1;
    ra <= a;
    back <= b;
    pnt <= p;
    corner <= c;
    @(posedge clk_i);
    rv <= 1'b0;
    do @(posedge clk_i); while (ov !== 1'b1);
    nreq++;
  endtask : req
  function automatic logic [127:0] slot(input int k);
    logic [31:0] v;
    v = 32'(k % 64);
    return {32'h40000000 | v, 32'h30000000 | v, 32'h20000000 | v, 32'h10000000 | v};
  endfunction : slot
  // read offset fixed at 60 so indices wrap past the last slot
  function automatic logic [127:0] expd(input int i, input logic [1:0] m, input logic [3:0] o,
      input logic b);
    logic [127:0] d, c;
    d = slot(60 + i + int'(b & m[0]));
    if (m[1]) d[31:0] = d[127:96];
    case (m)
      2'h0: c = 128'h0;
      2'h1: c = {SSW_F_ONE, 96'h0};
      2'h2: c = {4{SSW_F_ONE}};
      default: c = {4{pid}};
    endcase
    for (int n = 0; n < 4; n++) if (o[n]) d[32*n+:32] = c[32*n+:32];
    return d;
  endfunction : expd
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(SSW_ADR_CONST, 32'h0);
    rd(SSW_ADR_SPRITE, 32'h0);
    wb(1'b1, 8'h80, 32'hFFFFFFFF);
    rd(8'h80, 32'h0);
    wb(1'b1, 8'h04, 32'hFFFFFFFF);
    rd(8'h04, 32'hF6DFF6DF);
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
    do @(posedge clk_i); while (done !== 1'b1);
    wb(1'b1, SSW_ADR_CFG, 32'h0000003C);
    for (int m = 0; m < 8; m++) begin
      mm = 2'(m / 2);
      ovr = {mm[0], ~mm[0], ~mm[0], mm[0]};
      pid <= 32'h5A5A0000 | 32'(m);
      wb(1'b1, 8'h00, {16'h0009, ovr, 1'b0, mm, 1'b0, mm, 1'b0, 5'(4 + m / 2)});
      req(5'h00, 1'(m % 2), 1'b0, 2'h0);
      `CHK(od, expd(4 + m / 2, mm, ovr, 1'(m % 2)))
    end
    wb(1'b1, SSW_ADR_SPRITE, 32'h00000001);
    for (int o = 0; o < 2; o++) begin
      wb(1'b1, SSW_ADR_CFG, 32'h0000003C | (32'(o) << 8));
      for (int c = 0; c < 4; c++) begin
        cc = 2'(c);
        s_c = cc[0] ? SSW_F_ONE : SSW_F_ZERO;
        t_c = (cc[1] ^ o[0]) ? SSW_F_ONE : SSW_F_ZERO;
        e = {SSW_F_ONE, SSW_F_ZERO, t_c, s_c};
        req(5'h00, 1'b0, 1'b1, cc);
        `CHK(od, e)
        req(5'h01, 1'b0, 1'b1, cc);
        `CHK(od, slot(69))
      end
    end
    wb(1'b1, SSW_ADR_SPRITE, 32'h0);
    wb(1'b1, SSW_ADR_CONST, 32'h00020002);
    wb(1'b1, SSW_ADR_WRAP_LO, 32'hA0000005);
    wb(1'b1, SSW_ADR_WRAP_HI, 32'h0000000C);
    rd(SSW_ADR_WRAP_LO, 32'hA0000005);
    foreach (ia[i]) begin
      req(ia[i], 1'b0, 1'b0, 2'h0);
      `CHK({3'h0, oc, ow, ol}, ie[i])
    end
    // single byte lane write leaves the other lanes alone
    wb(1'b1, SSW_ADR_CONST, 32'hFFFFFFFF, 4'h4);
    rd(SSW_ADR_CONST, 32'h00FF0002);
    rd(SSW_ADR_STAT, 32'(nreq));
    // reset in mid-run clears control state and the result count
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    rd(SSW_ADR_CONST, 32'h0);
    rd(SSW_ADR_WRAP_LO, 32'h0);
    rd(SSW_ADR_STAT, 32'h0);
    finish_test();
  end
endmodule : tb
`default_nettype wire
